// ---- design/scroll_idle_pkg.sv ----
// Shared constants and types for the scroll start and reduced-colour command logic.
// Assumes a 10 MHz system clock and a 32-bit APB register port.
package scroll_idle_pkg;

  // Command codes as seen on the host data bus
  localparam logic [7:0] CMD_SCROLL_START = 8'h37;
  localparam logic [7:0] CMD_REDUCED_EXIT = 8'h38;
  localparam logic [7:0] CMD_REDUCED_ENTER = 8'h39;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_AREA = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PENDING = 8'h0C;

  // Control register fields
  localparam int CTRL_SOFT_RESET_BIT = 0;
  localparam int CTRL_PARTIAL_BIT = 1;

  // Area register fields
  localparam int AREA_TOP_LSB = 0;
  localparam int AREA_SCROLL_LSB = 16;

  // Status register fields
  localparam int STAT_IDLE_BIT = 0;
  localparam int STAT_PENDING_BIT = 1;
  localparam int STAT_STATE_LSB = 2;
  localparam int STAT_PTR_LSB = 16;

  // Reset values
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [15:0] TOP_RESET = 16'h0000;
  localparam logic [15:0] SCROLL_AREA_RESET = 16'h0140;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  // One sample of the host parallel pins
  typedef struct packed {
    logic cmdOrParamSelect;
    logic readStrobeN;
    logic writeStrobeN;
    logic [7:0] data;
  } host_pins_type;

  // One pixel, six bits per channel
  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } pixel_type;

  // Command sequencer, Gray coded along the parameter path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PARAM_HIGH = 2'b01,
    ST_PARAM_LOW = 2'b11
  } cmd_state_type;

endpackage

// ---- design/scroll_idle_cmd.sv ----
// Decoder for the scroll start line command and the two reduced-colour commands,
// with line mapping for the panel scan and the reduced-colour pixel filter.
// Assumes host pins are asynchronous and a scan timing block on clk supplies
// frameStart, scanLine and pixels; software reaches control over APB.
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RULE_01] Command byte 37h starts the scroll start line command with parameters.
// [RULE_02] First parameter is pointer high byte, second is low byte, forming 16 bits.
// [RULE_03] Pointer line is shown as first panel line after the top fixed area.
// [RULE_04] A new pointer becomes visible only at the start of the next panel scan.
// [RULE_05] Scroll start command is ignored while partial mode is on.
// [RULE_06] Pointer works together with top fixed, scroll and bottom fixed areas.
// [RULE_07] Command byte 38h leaves reduced-colour mode.
// [RULE_08] With reduced colour off, full frame memory depth is shown.
// [RULE_09] Exit command while already in full colour changes nothing.
// [RULE_10] Command byte 39h enters reduced-colour mode.
// [RULE_11] Reduced colour shows eight colours from each channel's top bit.
// [RULE_12] Channel is fully on when its top bit is 1, off otherwise.
// [RULE_13] Resets clear the pointer and leave reduced colour off.
// [RULE_14] Select low marks command, high a parameter, taken on write strobe rise.
module scroll_idle_cmd
  import scroll_idle_pkg::*;
#(
  parameter int LINE_WIDTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire scroll_idle_pkg::host_pins_type hostPins,
  input wire logic frameStart,
  input wire logic [LINE_WIDTH-1:0] scanLine,
  input wire scroll_idle_pkg::pixel_type pixelIn,
  output scroll_idle_pkg::pixel_type pixelOut,
  output logic [LINE_WIDTH-1:0] memLine,
  output logic [15:0] scrollLinePointer,
  output logic idleMode
);
  import scroll_idle_pkg::*;

  host_pins_type syncStage [SYNC_STAGES];
  host_pins_type pinStable;
  logic byteStrobe;
  logic byteIsParam;
  logic [7:0] byteData;
  cmd_state_type cmdState;
  logic [7:0] pointerHigh;
  logic [15:0] pendingPtr;
  logic pendingValid;
  logic partialMode;
  logic softReset;
  logic [15:0] topFixed;
  logic [15:0] scrollArea;
  logic apbAccess;
  logic apbWrite;
  logic cmdTaken;
  logic paramTaken;
  logic newPointer;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // Expand one channel's top bit to fully on or fully off
  function automatic logic [5:0] reduce_channel(input logic [5:0] level);
    reduce_channel = {6{level[5]}};
  endfunction

  // Map a panel line onto a frame memory line within the scroll area
  function automatic logic [LINE_WIDTH-1:0] map_line(
    input logic [LINE_WIDTH-1:0] line,
    input logic [15:0] top,
    input logic [15:0] area,
    input logic [15:0] ptr
  );
    logic [LINE_WIDTH:0] offset;
    offset = '0;
    if (line < LINE_WIDTH'(top) || ({1'b0, line} >= ({1'b0, LINE_WIDTH'(top)} + {1'b0, LINE_WIDTH'(area)}))) begin
      map_line = line;
    end else begin
      offset = {1'b0, line - LINE_WIDTH'(top)} + {1'b0, LINE_WIDTH'(ptr) - LINE_WIDTH'(top)};
      if (offset >= {1'b0, LINE_WIDTH'(area)}) begin
        offset = offset - {1'b0, LINE_WIDTH'(area)};
      end
      map_line = LINE_WIDTH'(top) + offset[LINE_WIDTH-1:0];
    end
  endfunction

  // Three-stage pin synchroniser; the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        syncStage[i] <= '{cmdOrParamSelect: 1'b1, readStrobeN: 1'b1, writeStrobeN: 1'b1, data: 8'h00};
      end
    end else begin
      syncStage[0] <= hostPins;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        syncStage[i] <= syncStage[i-1];
      end
    end
  end

  // Accept a pin change only once the last two stages agree, filtering glitches
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinStable <= '{cmdOrParamSelect: 1'b1, readStrobeN: 1'b1, writeStrobeN: 1'b1, data: 8'h00};
    end else if (syncStage[1] == syncStage[2]) begin
      pinStable <= syncStage[2];
    end
  end

  // Byte taken on write strobe rise while read strobe stays high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      byteStrobe <= 1'b0;
      byteIsParam <= 1'b0;
      byteData <= 8'h00;
    end else begin
      byteStrobe <= 1'b0;
      if (syncStage[1] == syncStage[2] && !pinStable.writeStrobeN && syncStage[2].writeStrobeN
          && syncStage[2].readStrobeN) begin
        byteStrobe <= 1'b1; // RULE_14
        byteIsParam <= syncStage[2].cmdOrParamSelect; // RULE_14
        byteData <= syncStage[2].data;
      end
    end
  end

  assign cmdTaken = byteStrobe && !byteIsParam;
  assign paramTaken = byteStrobe && byteIsParam;
  assign newPointer = paramTaken && cmdState == ST_PARAM_LOW && !partialMode;

  // Command sequencer; any new command aborts an unfinished parameter list
  always_ff @(posedge clk) begin
    if (sys_rst || softReset) begin
      cmdState <= ST_IDLE;
      pointerHigh <= 8'h00;
    end else if (cmdTaken) begin
      if (byteData == CMD_SCROLL_START && !partialMode) begin
        cmdState <= ST_PARAM_HIGH; // RULE_01 RULE_05
      end else begin
        cmdState <= ST_IDLE;
      end
    end else if (paramTaken) begin
      case (cmdState)
        ST_PARAM_HIGH: begin
          pointerHigh <= byteData; // RULE_02
          cmdState <= ST_PARAM_LOW;
        end
        ST_PARAM_LOW: begin
          cmdState <= ST_IDLE;
        end
        default: begin
          cmdState <= ST_IDLE;
        end
      endcase
    end
  end

  // Pending pointer; a pointer arriving on a frame start stays pending for the next
  always_ff @(posedge clk) begin
    if (sys_rst || softReset) begin
      pendingPtr <= PTR_RESET; // RULE_13
      pendingValid <= 1'b0;
    end else if (newPointer) begin
      pendingPtr <= {pointerHigh, byteData}; // RULE_02
      pendingValid <= 1'b1;
    end else if (frameStart) begin
      pendingValid <= 1'b0;
    end
  end

  // Pointer shown only from the next scan onward, so a frame never tears
  always_ff @(posedge clk) begin
    if (sys_rst || softReset) begin
      scrollLinePointer <= PTR_RESET; // RULE_13
    end else if (frameStart && pendingValid) begin
      scrollLinePointer <= pendingPtr; // RULE_04
    end
  end

  // Reduced-colour mode; exit while already off leaves it off
  always_ff @(posedge clk) begin
    if (sys_rst || softReset) begin
      idleMode <= 1'b0; // RULE_13
    end else if (cmdTaken && byteData == CMD_REDUCED_EXIT) begin
      idleMode <= 1'b0; // RULE_07 RULE_09
    end else if (cmdTaken && byteData == CMD_REDUCED_ENTER) begin
      idleMode <= 1'b1; // RULE_10
    end
  end

  // Panel line to frame memory line, using the fixed and scroll areas
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      memLine <= '0;
    end else begin
      memLine <= map_line(scanLine, topFixed, scrollArea, scrollLinePointer); // RULE_03 RULE_06
    end
  end

  // Pixel filter; full depth passes untouched when reduced colour is off
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pixelOut <= '0;
    end else if (idleMode) begin
      pixelOut <= '{red: reduce_channel(pixelIn.red), green: reduce_channel(pixelIn.green),
                    blue: reduce_channel(pixelIn.blue)}; // RULE_11 RULE_12
    end else begin
      pixelOut <= pixelIn; // RULE_08
    end
  end

  // APB: one wait state, so read data and error leave straight from flops
  assign apbAccess = psel && penable && !pready;
  assign apbWrite = psel && penable && pready && pwrite;

  // Read mux and address check
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      OFS_CTRL: begin
        next_prdata[CTRL_PARTIAL_BIT] = partialMode;
      end
      OFS_AREA: begin
        next_prdata = {scrollArea, topFixed};
      end
      OFS_STATUS: begin
        next_prdata[STAT_IDLE_BIT] = idleMode;
        next_prdata[STAT_PENDING_BIT] = pendingValid;
        next_prdata[STAT_STATE_LSB +: 2] = cmdState;
        next_prdata[STAT_PTR_LSB +: 16] = scrollLinePointer;
      end
      OFS_PENDING: begin
        next_prdata[15:0] = pendingPtr;
      end
      default: begin
        next_pslverr = 1'b1;
      end
    endcase
  end

  // APB response flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apbAccess;
      pslverr <= apbAccess && next_pslverr;
      prdata <= (apbAccess && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // Control register writes; soft reset is a one-cycle pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      partialMode <= 1'b0;
      softReset <= 1'b0;
      topFixed <= TOP_RESET;
      scrollArea <= SCROLL_AREA_RESET;
    end else begin
      softReset <= apbWrite && paddr == OFS_CTRL && pwdata[CTRL_SOFT_RESET_BIT];
      if (apbWrite && paddr == OFS_CTRL) begin
        partialMode <= pwdata[CTRL_PARTIAL_BIT];
      end
      if (apbWrite && paddr == OFS_AREA) begin
        topFixed <= pwdata[AREA_TOP_LSB +: 16];
        scrollArea <= pwdata[AREA_SCROLL_LSB +: 16];
      end
    end
  end

  // Checks
  sequence s_scrollCmd;
    cmdTaken && byteData == CMD_SCROLL_START && !partialMode && !softReset;
  endsequence

  sequence s_lowParam;
    paramTaken && cmdState == ST_PARAM_LOW && !partialMode && !softReset;
  endsequence

  property p_scroll_decode;
    @(posedge clk) disable iff (sys_rst)
    s_scrollCmd |=> cmdState == ST_PARAM_HIGH;
  endproperty
  a_scroll_decode: assert property (p_scroll_decode) else $error("scroll command not decoded"); // RULE_01

  property p_pointer_assembly;
    @(posedge clk) disable iff (sys_rst)
    s_lowParam |=> pendingPtr == {$past(pointerHigh), $past(byteData)} && pendingValid;
  endproperty
  a_pointer_assembly: assert property (p_pointer_assembly) else $error("pointer bytes misassembled"); // RULE_02

  property p_first_scroll_line;
    @(posedge clk) disable iff (sys_rst)
    (scanLine == LINE_WIDTH'(topFixed) && scrollArea != 16'h0000 && scrollLinePointer >= topFixed
     && scrollLinePointer < topFixed + scrollArea) |=> memLine == LINE_WIDTH'($past(scrollLinePointer));
  endproperty
  a_first_scroll_line: assert property (p_first_scroll_line) else $error("first scroll line wrong"); // RULE_03

  property p_apply_on_frame;
    @(posedge clk) disable iff (sys_rst)
    !$stable(scrollLinePointer) |-> $past(frameStart) || $past(softReset);
  endproperty
  a_apply_on_frame: assert property (p_apply_on_frame) else $error("pointer changed mid frame"); // RULE_04

  property p_partial_ignore;
    @(posedge clk) disable iff (sys_rst)
    (cmdTaken && byteData == CMD_SCROLL_START && partialMode) |=> cmdState == ST_IDLE;
  endproperty
  a_partial_ignore: assert property (p_partial_ignore) else $error("scroll accepted in partial mode"); // RULE_05

  property p_fixed_passthrough;
    @(posedge clk) disable iff (sys_rst)
    (scanLine < LINE_WIDTH'(topFixed)) |=> memLine == $past(scanLine);
  endproperty
  a_fixed_passthrough: assert property (p_fixed_passthrough) else $error("fixed area line remapped"); // RULE_06

  property p_exit_reduced;
    @(posedge clk) disable iff (sys_rst)
    (cmdTaken && byteData == CMD_REDUCED_EXIT) |=> !idleMode [*2];
  endproperty
  a_exit_reduced: assert property (p_exit_reduced) else $error("reduced colour not left"); // RULE_07

  property p_full_depth;
    @(posedge clk) disable iff (sys_rst)
    !idleMode && !sys_rst |=> pixelOut == $past(pixelIn);
  endproperty
  a_full_depth: assert property (p_full_depth) else $error("full colour pixel altered"); // RULE_08

  property p_exit_noop;
    @(posedge clk) disable iff (sys_rst)
    (cmdTaken && byteData == CMD_REDUCED_EXIT && !idleMode) |=> $stable(idleMode) && $stable(cmdState);
  endproperty
  a_exit_noop: assert property (p_exit_noop) else $error("exit in full colour changed state"); // RULE_09

  property p_enter_reduced;
    @(posedge clk) disable iff (sys_rst)
    (cmdTaken && byteData == CMD_REDUCED_ENTER && !softReset) |=> idleMode;
  endproperty
  a_enter_reduced: assert property (p_enter_reduced) else $error("reduced colour not entered"); // RULE_10

  property p_top_bit_colour;
    @(posedge clk) disable iff (sys_rst)
    idleMode |=> pixelOut.red == {6{$past(pixelIn.red[5])}} && pixelOut.green == {6{$past(pixelIn.green[5])}}
                 && pixelOut.blue == {6{$past(pixelIn.blue[5])}};
  endproperty
  a_top_bit_colour: assert property (p_top_bit_colour) else $error("reduced colour pixel wrong"); // RULE_11 RULE_12

  property p_soft_reset;
    @(posedge clk) disable iff (sys_rst)
    softReset |=> scrollLinePointer == PTR_RESET && !idleMode && !pendingValid;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state"); // RULE_13

  property p_strobe_qualify;
    @(posedge clk) disable iff (sys_rst)
    byteStrobe |-> $past(syncStage[2].readStrobeN) && $past(syncStage[2].writeStrobeN) && $past(!pinStable.writeStrobeN);
  endproperty
  a_strobe_qualify: assert property (p_strobe_qualify) else $error("byte taken without strobe rise"); // RULE_14

endmodule
`default_nettype wire

// ---- sim/host_mcu_model.sv ----
// Host processor model that writes command and parameter bytes on the parallel pins.
// Assumes the bench clock paces it; strobes idle high and the read strobe falls only in sendBlocked.
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
  input wire logic clk,
  output scroll_idle_pkg::host_pins_type hostPins
);
  import scroll_idle_pkg::*;

  // Pins park with strobes high before the first byte
  initial hostPins = '{cmdOrParamSelect: 1'b1, readStrobeN: 1'b1, writeStrobeN: 1'b1, data: 8'hFF};

  // One byte: low and high strobe phases of five cycles clear the pin filter
  task automatic sendByte(input logic sel, input logic [7:0] d);
    @(posedge clk);
    hostPins.cmdOrParamSelect <= sel;
    hostPins.data <= d;
    hostPins.writeStrobeN <= 1'b0;
    repeat (5) @(posedge clk);
    hostPins.writeStrobeN <= 1'b1;
    repeat (5) @(posedge clk);
    hostPins.data <= ~d; // Hold time over, so the bus stops showing the old byte
    @(posedge clk);
  endtask

  // Command byte with the read strobe held low across it; the device must drop it
  task automatic sendBlocked(input logic [7:0] d);
    @(posedge clk);
    hostPins.readStrobeN <= 1'b0;
    sendByte(1'b0, d);
    hostPins.readStrobeN <= 1'b1;
  endtask

  // Scroll start command, then pointer high byte and low byte
  task automatic sendScroll(input logic [15:0] p);
    sendByte(1'b0, CMD_SCROLL_START);
    sendByte(1'b1, p[15:8]);
    sendByte(1'b1, p[7:0]);
  endtask
endmodule
`default_nettype wire

// ---- sim/scroll_start_and_idle_color_cmds_tb_top.sv ----
// Self-checking bench for the scroll start and reduced-colour command logic.
// Assumes the host model on the pins, an APB master here, and a scan stream driven here.
`timescale 1ns/1ps
`default_nettype none
module scroll_start_and_idle_color_cmds_tb_top;
  import scroll_idle_pkg::*;
  logic clk, sys_rst, psel, penable, pwrite, frameStart, pready, pslverr, idleMode, err, curIdle;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] scanLine, memLine, scrollLinePointer, curTop, curArea, curPtr, newPtr;
  pixel_type pixelIn, pixelOut;
  host_pins_type hostPins;
  int mismatches, total_checks;

  scroll_idle_cmd dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hostPins(hostPins), .frameStart(frameStart), .scanLine(scanLine), .pixelIn(pixelIn),
    .pixelOut(pixelOut), .memLine(memLine), .scrollLinePointer(scrollLinePointer), .idleMode(idleMode));
  host_mcu_model host (.clk(clk), .hostPins(hostPins));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Expected panel-to-memory line; pointer is kept inside the scroll area by the stimulus
  function automatic logic [15:0] expLine(input logic [15:0] l);
    int a;
    a = int'(l) - int'(curTop);
    if (a < 0 || a >= int'(curArea)) return l;
    return 16'(int'(curTop) + (a + int'(curPtr) - int'(curTop)) % int'(curArea));
  endfunction

  // Expected pixel: top bit of each channel fills the channel in reduced colour
  function automatic pixel_type expPix(input pixel_type p);
    if (!curIdle) return p;
    return '{red: {6{p.red[5]}}, green: {6{p.green[5]}}, blue: {6{p.blue[5]}}};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // APB transfer; pready is looked at once settled, so the next edge completes the access
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (int i = 0; i <= 20; i++) begin
      @(posedge clk);
      #1;
      if (pready === 1'b1) break;
      if (i == 20) begin
        mismatches++;
        test_done();
      end
    end
    r = prdata;
    e = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One scan sample; line mapping and pixel filter answer one cycle later
  task automatic scanStep(input logic [15:0] l, input pixel_type p);
    @(posedge clk);
    scanLine <= l;
    pixelIn <= p;
    tick(1);
    chk(32'(memLine), 32'(expLine(l)));
    chk(32'(pixelOut), 32'(expPix(p)));
  endtask

  task automatic frame();
    @(posedge clk);
    frameStart <= 1'b1;
    @(posedge clk);
    frameStart <= 1'b0;
    tick(2);
  endtask

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, frameStart} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    scanLine = 16'h0000;
    pixelIn = '0;
    {mismatches, total_checks} = 0;
    {curTop, curPtr, curIdle} = '0;
    curArea = 16'h0140;
    void'($urandom(32'h0713));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    tick(6);
    chk(32'(scrollLinePointer), 32'h0000_0000);
    chk(32'(idleMode), 32'h0000_0000);
    apb(1'b0, OFS_AREA, 32'h0000_0000, rd, err);
    chk(rd, 32'h0140_0000);
    apb(1'b0, 8'h10, 32'h0000_0000, rd, err);
    chk(32'(err), 32'h0000_0001);
    // Enter twice, then exit twice; repeats must leave the mode alone
    for (int k = 0; k < 4; k++) begin
      host.sendByte(1'b0, k < 2 ? CMD_REDUCED_ENTER : CMD_REDUCED_EXIT);
      curIdle = (k < 2);
      tick(1);
      chk(32'(idleMode), 32'(curIdle));
      scanStep(16'h0005, pixel_type'(18'h1_F7DF));
      scanStep(16'h0006, pixel_type'(18'h2_0820));
      repeat (4) scanStep(16'($urandom % 320), pixel_type'(18'($urandom)));
    end
    // A byte written while the read strobe is low must not count
    host.sendBlocked(CMD_REDUCED_ENTER);
    tick(1);
    chk(32'(idleMode), 32'h0000_0000);
    // New pointer waits for the next scan; includes the last line of the area
    for (int k = 0; k < 3; k++) begin
      curTop = (k == 0) ? 16'h0000 : 16'($urandom % 8);
      curArea = (k == 0) ? 16'h0140 : 16'(16 + $urandom % 64);
      newPtr = (k == 1) ? curTop + curArea - 16'h0001 : 16'(curTop + $urandom % curArea);
      apb(1'b1, OFS_AREA, {curArea, curTop}, rd, err);
      host.sendScroll(newPtr);
      tick(2);
      chk(32'(scrollLinePointer), 32'(curPtr));
      apb(1'b0, OFS_STATUS, 32'h0000_0000, rd, err);
      chk(32'(rd[STAT_PENDING_BIT]), 32'h0000_0001);
      apb(1'b0, OFS_PENDING, 32'h0000_0000, rd, err);
      chk(32'(rd[15:0]), 32'(newPtr));
      frame();
      curPtr = newPtr;
      chk(32'(scrollLinePointer), 32'(curPtr));
      for (int j = 0; j < 6; j++) begin
        scanStep(16'(j == 0 ? curTop : j == 1 ? curTop + curArea : $urandom % (curTop + curArea + 4)),
                 pixel_type'(18'($urandom)));
      end
    end
    // Partial mode drops the command
    apb(1'b1, OFS_CTRL, 32'h0000_0002, rd, err);
    host.sendScroll(curPtr ^ 16'h0001);
    apb(1'b0, OFS_STATUS, 32'h0000_0000, rd, err);
    chk(32'(rd[STAT_PENDING_BIT]), 32'h0000_0000);
    frame();
    chk(32'(scrollLinePointer), 32'(curPtr));
    apb(1'b1, OFS_CTRL, 32'h0000_0000, rd, err);
    // Soft reset clears pointer and reduced colour
    host.sendByte(1'b0, CMD_REDUCED_ENTER);
    apb(1'b1, OFS_CTRL, 32'h0000_0001, rd, err);
    tick(2);
    chk(32'(scrollLinePointer), 32'h0000_0000);
    chk(32'(idleMode), 32'h0000_0000);
    // Hardware reset in mid-run, with a pointer shown and reduced colour on
    host.sendScroll(16'h0003);
    host.sendByte(1'b0, CMD_REDUCED_ENTER);
    frame();
    chk(32'(scrollLinePointer), 32'h0000_0003);
    chk(32'(idleMode), 32'h0000_0001);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    tick(6);
    chk(32'(scrollLinePointer), 32'h0000_0000);
    chk(32'(idleMode), 32'h0000_0000);
    test_done();
  end

  // Watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
